// ==== hdl/ptm_pkg.sv ====
// Package for the paired 16/32-bit timer block
package ptm_pkg;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [5:0] OFF_CTL_LO_A  = 6'h00;
   localparam logic [5:0] OFF_CTL_HI_A  = 6'h04;
   localparam logic [5:0] OFF_CNT_LO_A  = 6'h08;
   localparam logic [5:0] OFF_CNT_HI_A  = 6'h0c;
   localparam logic [5:0] OFF_PER_LO_A  = 6'h10;
   localparam logic [5:0] OFF_PER_HI_A  = 6'h14;
   localparam logic [5:0] OFF_CTL_LO_B  = 6'h18;
   localparam logic [5:0] OFF_CTL_HI_B  = 6'h1c;
   localparam logic [5:0] OFF_CNT_LO_B  = 6'h20;
   localparam logic [5:0] OFF_CNT_HI_B  = 6'h24;
   localparam logic [5:0] OFF_PER_LO_B  = 6'h28;
   localparam logic [5:0] OFF_PER_HI_B  = 6'h2c;
   localparam logic [5:0] OFF_IRQ       = 6'h30;

   // -------------------------------------------------------------
   // Control field positions
   // -------------------------------------------------------------
   localparam int BIT_RUN    = 15;
   localparam int BIT_IDLE   = 13;
   localparam int BIT_GATE   = 6;
   localparam int BIT_PS_HI  = 5;
   localparam int BIT_PS_LO  = 4;
   localparam int BIT_PAIR   = 3;
   localparam int BIT_CSRC   = 1;
   // Writable bits of each control register
   localparam logic [15:0] CTL_LO_MASK = 16'ha07a;
   localparam logic [15:0] CTL_HI_MASK = 16'ha072;

   // IRQ register: flag bits 3:0, enable bits 7:4, priorities 14:8
   localparam int BIT_IRQ_EN  = 4;
   localparam int BIT_PRIO_A  = 8;
   localparam int BIT_PRIO_B  = 12;

   // -------------------------------------------------------------
   // Reset values and timing
   // -------------------------------------------------------------
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] PER_RESET = 16'hffff;
   localparam logic [7:0]  PS_DIV8   = 8'h07;
   localparam logic [7:0]  PS_DIV64  = 8'h3f;
   localparam logic [7:0]  PS_DIV256 = 8'hff;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ptm_wr_s;

endpackage

// ==== hdl/ptm_timer.sv ====
// Paired 16/32-bit timers with AXI4-Lite register access
`timescale 1ns/1ps
// Overview of operation
// - Pair mode: high timer interrupt enable, flag, priority serve the pair.
// - Chaining only pairs timer two with three, and four with five.
// - Pair supports timer, gated accumulation and synchronous external counting.
// - In pair mode low timer fields give prescale, clock source and gating.
// - Pair period is high period register over low period register.
// - Pair interrupt is raised as the high timer's interrupt.
// - Pair count lives in high count register over low count register.
// - Idle-halt set stops counting during idle; clear keeps counting.
// - Clock-source set counts external input, clear counts internal clock.
// - In pair mode high timer run, gate, prescale, source bits ignored.
// - Unimplemented control bits read back as zero.
// - Timer and gated modes use instruction clock; counter mode uses pin.
// - Low and high timers both sync the pin before the prescaler.
module ptm_timer (
   input  wire logic        sys_clk,         // 125 MHz clock
   input  wire logic        rst,             // Sync reset, active high
   input  wire logic [3:0]  ext_count_pin,   // External count inputs, 2..5
   input  wire logic [3:0]  gate_pin,        // Gate inputs, 2..5
   input  wire logic        cpu_idle,        // Device in idle mode
   output logic      [1:0]  pair_irq,        // Interrupt of timer three, five
   output logic      [1:0]  low_irq,         // Interrupt of timer two, four
   input  wire logic [5:0]  s_axi_awaddr,    // Write address
   input  wire logic        s_axi_awvalid,   // Write address valid
   output logic             s_axi_awready,   // Write address ready
   input  wire logic [31:0] s_axi_wdata,     // Write data
   input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
   input  wire logic        s_axi_wvalid,    // Write data valid
   output logic             s_axi_wready,    // Write data ready
   output logic [1:0]       s_axi_bresp,     // Write response
   output logic             s_axi_bvalid,    // Write response valid
   input  wire logic        s_axi_bready,    // Write response ready
   input  wire logic [5:0]  s_axi_araddr,    // Read address
   input  wire logic        s_axi_arvalid,   // Read address valid
   output logic             s_axi_arready,   // Read address ready
   output logic [31:0]      s_axi_rdata,     // Read data
   output logic [1:0]       s_axi_rresp,     // Read response
   output logic             s_axi_rvalid,    // Read data valid
   input  wire logic        s_axi_rready     // Read data ready
);
   import ptm_pkg::*;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [7:0] ps_limit(input logic [1:0] code);
      case (code)
         2'b11:   ps_limit = PS_DIV256;
         2'b10:   ps_limit = PS_DIV64;
         2'b01:   ps_limit = PS_DIV8;
         default: ps_limit = 8'h00;
      endcase
   endfunction

   // -------------------------------------------------------------
   // Registers; index t: 0=two, 1=three, 2=four, 3=five
   // -------------------------------------------------------------
   logic [15:0] ctl_q [4];
   logic [15:0] cnt_q [4];
   logic [15:0] per_q [4];
   logic [3:0]  flag_q;
   logic [3:0]  ien_q;
   logic [2:0]  prio_q [2];
   logic [3:0]  pin_s1_q, pin_s2_q, pin_s3_q;
   logic [3:0]  gate_s1_q, gate_s2_q, gate_s3_q;

   always_ff @(posedge sys_clk) begin
      pin_s1_q  <= ext_count_pin;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      gate_s1_q <= gate_pin;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
   end

   wire [3:0] pin_rise  = pin_s2_q & ~pin_s3_q;
   wire [3:0] gate_fall = ~gate_s2_q & gate_s3_q;

   // Bus decode
   logic        aw_hold_q, w_hold_q;
   logic [5:0]  aw_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   wire  do_wr   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   wire  lo_strb = ws_q[0] & ws_q[1];
   function automatic logic wr_hit(input logic [5:0] off);
      wr_hit = do_wr & (aw_q == off) & lo_strb;
   endfunction

   wire [1:0] pair_on = {ctl_q[2][BIT_PAIR], ctl_q[0][BIT_PAIR]};

   // -------------------------------------------------------------
   // Per-timer tick generation
   // -------------------------------------------------------------
   wire  [3:0]  tick;
   wire  [3:0]  gate_evt;
   wire  [3:0]  low_wrap;
   logic [3:0]  wrap;
   logic [7:0]  psc_q [4];
   logic [15:0] cnt_d [4];

   genvar t;
   generate
      for (t = 0; t < 4; t++) begin : g_tmr
         localparam int LO = t & 2;
         localparam bit IS_HI = (t % 2) == 1;
         localparam logic [1:0] SELF = 2'(t);
         localparam logic [1:0] LOW  = 2'(LO);
         // paired high timer takes low timer fields
         // high timer own fields, except idle, ignored in pair mode
         wire paired = pair_on[t/2];
         wire [15:0] ctl = (IS_HI && paired) ? ctl_q[LO] : ctl_q[t];
         wire [1:0] src = (IS_HI && paired) ? LOW : SELF;
         // idle halt; a pair obeys the high timer bit only
         wire idle_bit = paired ? ctl_q[t | 1][BIT_IDLE] :
                                  ctl_q[t][BIT_IDLE];
         wire halt = cpu_idle & idle_bit;
         wire run  = ctl[BIT_RUN] & ~halt;
         // mode from source and gate bits
         // clock source select; internal vs pin
         wire ext  = ctl[BIT_CSRC];
         // gate acts only on internal clock
         wire gated = ctl[BIT_GATE] & ~ext;
         wire gate_ok = ~gated | gate_s2_q[src[1:0]];
         // high and low both sync before prescaler
         wire pre_in = ext ? (IS_HI ? pin_rise[src[1:0]] :
                              pin_s2_q[src[1:0]] & ~pin_s3_q[src[1:0]])
                           : 1'b1;
         wire [7:0] lim = ps_limit(ctl[BIT_PS_HI:BIT_PS_LO]);
         wire pre_tick = run & gate_ok & pre_in & (psc_q[t] == lim);
         always_ff @(posedge sys_clk) begin
            if (rst || !run)
               psc_q[t] <= 8'h00;
            else if (pre_in && gate_ok)
               psc_q[t] <= (psc_q[t] == lim) ? 8'h00 : psc_q[t] + 8'h01;
         end
         assign gate_evt[t] = gated & run & gate_fall[src[1:0]];
         // low run bit drives whole pair when paired
         if (IS_HI) begin : g_hi
            assign tick[t] = paired ? low_wrap[t-1] : pre_tick;
         end else begin : g_lo
            assign tick[t] = pre_tick;
         end
      end
   endgenerate

   // -------------------------------------------------------------
   // Count, period match and flags
   // -------------------------------------------------------------
   // 32-bit period; 32-bit count in register pair
   wire [31:0] per32_a = {per_q[1], per_q[0]};
   wire [31:0] per32_b = {per_q[3], per_q[2]};
   wire [31:0] cnt32_a = {cnt_q[1], cnt_q[0]};
   wire [31:0] cnt32_b = {cnt_q[3], cnt_q[2]};
   wire [1:0]  m32 = {cnt32_b == per32_b, cnt32_a == per32_a};
   // Carry out of each low timer feeds its high partner
   assign low_wrap = {1'b0, tick[2] & (&cnt_q[2]),
                      1'b0, tick[0] & (&cnt_q[0])};

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wrap[i]     = (cnt_q[i] == per_q[i]);
         cnt_d[i]    = cnt_q[i];
      end
      for (int p = 0; p < 2; p++) begin
         if (pair_on[p]) begin
            if (tick[2*p]) begin
               cnt_d[2*p]     = m32[p] ? CNT_RESET : cnt_q[2*p] + 16'h1;
               cnt_d[2*p+1]   = m32[p] ? CNT_RESET :
                  cnt_q[2*p+1] + {15'h0, &cnt_q[2*p]};
            end
            wrap[2*p]   = 1'b0;
            wrap[2*p+1] = tick[2*p] & m32[p];
         end else begin
            for (int h = 0; h < 2; h++) begin
               if (tick[2*p+h])
                  cnt_d[2*p+h] = wrap[2*p+h] ? CNT_RESET :
                                 cnt_q[2*p+h] + 16'h1;
               wrap[2*p+h] = tick[2*p+h] & wrap[2*p+h];
            end
         end
      end
   end

   // low flags unused in pair mode; pair event flags high timer
   wire [3:0] pair_mask = {1'b1, ~pair_on[1], 1'b1, ~pair_on[0]};
   wire [3:0] gev_route = {gate_evt[3] | (pair_on[1] & gate_evt[2]),
                           gate_evt[2] & ~pair_on[1],
                           gate_evt[1] | (pair_on[0] & gate_evt[0]),
                           gate_evt[0] & ~pair_on[0]};
   wire [3:0] flag_set  = (wrap | gev_route) & pair_mask;
   wire [3:0] flag_clr  = wr_hit(OFF_IRQ) ? ~wd_q[3:0] : 4'h0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flag_q <= 4'h0;
         ien_q  <= 4'h0;
         prio_q[0] <= 3'h0;
         prio_q[1] <= 3'h0;
      end else begin
         // Set wins over clear
         flag_q <= (flag_q & ~flag_clr) | flag_set;
         if (wr_hit(OFF_IRQ)) begin
            ien_q     <= wd_q[BIT_IRQ_EN +: 4];
            prio_q[0] <= wd_q[BIT_PRIO_A +: 3];
            prio_q[1] <= wd_q[BIT_PRIO_B +: 3];
         end
      end
   end

   assign pair_irq = {flag_q[3] & ien_q[3], flag_q[1] & ien_q[1]};
   assign low_irq  = {flag_q[2] & ien_q[2] & ~pair_on[1],
                      flag_q[0] & ien_q[0] & ~pair_on[0]};

   // -------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------
   wire [5:0] ctl_off [4] = '{OFF_CTL_LO_A, OFF_CTL_HI_A,
                              OFF_CTL_LO_B, OFF_CTL_HI_B};
   wire [5:0] cnt_off [4] = '{OFF_CNT_LO_A, OFF_CNT_HI_A,
                              OFF_CNT_LO_B, OFF_CNT_HI_B};
   wire [5:0] per_off [4] = '{OFF_PER_LO_A, OFF_PER_HI_A,
                              OFF_PER_LO_B, OFF_PER_HI_B};
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (rst) begin
            ctl_q[i] <= CTL_RESET;
            cnt_q[i] <= CNT_RESET;
            per_q[i] <= PER_RESET;
         end else begin
            if (wr_hit(ctl_off[i]))
               ctl_q[i] <= wd_q[15:0] &
                           ((i % 2 == 0) ? CTL_LO_MASK : CTL_HI_MASK);
            cnt_q[i] <= wr_hit(cnt_off[i]) ? wd_q[15:0] : cnt_d[i];
            if (wr_hit(per_off[i]))
               per_q[i] <= wd_q[15:0];
         end
      end
   end

   // -------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------
   function automatic logic mapped(input logic [5:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= OFF_IRQ);
   endfunction

   assign s_axi_awready = ~aw_hold_q;
   assign s_axi_wready  = ~w_hold_q;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         aw_q         <= 6'h00;
         wd_q         <= 32'h0;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wd_q     <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
         end
      end
   end

   wire [31:0] irq_word = {17'h0, prio_q[1], 1'b0, prio_q[0],
                           ien_q, flag_q};
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      for (int i = 0; i < 4; i++) begin
         if (s_axi_araddr == ctl_off[i]) rd_mux = {16'h0, ctl_q[i]};
         if (s_axi_araddr == cnt_off[i]) rd_mux = {16'h0, cnt_q[i]};
         if (s_axi_araddr == per_off[i]) rd_mux = {16'h0, per_q[i]};
      end
      if (s_axi_araddr == OFF_IRQ) rd_mux = irq_word;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   a_pair_lowflag: assert property (@(posedge sys_clk) disable iff (rst)
      pair_on[0] |-> !flag_set[0])
      else $error("low flag set in pair mode");
   a_pair_irq_hi: assert property (@(posedge sys_clk) disable iff (rst)
      (pair_on[0] && tick[0] && m32[0]) |=> flag_q[1])
      else $error("pair wrap did not flag high timer");
   a_wrap_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (!pair_on[0] && tick[0] && wrap[0] && !wr_hit(OFF_CNT_LO_A))
      |=> cnt_q[0] == 16'h0)
      else $error("count did not wrap to zero");
   a_idle_stop: assert property (@(posedge sys_clk) disable iff (rst)
      (cpu_idle && ctl_q[1][BIT_IDLE] && pair_on[0]) |-> !tick[0])
      else $error("pair counted while idle halted");
   a_ctl_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (ctl_q[1] & ~CTL_HI_MASK) == 16'h0)
      else $error("unimplemented bit set");
   a_stop_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (!ctl_q[0][BIT_RUN] && !wr_hit(OFF_CNT_LO_A)) |=>
      $stable(cnt_q[0]))
      else $error("stopped timer counted");
   a_div8_gap: assert property (@(posedge sys_clk) disable iff (rst)
      (tick[0] && !ctl_q[0][BIT_CSRC] && !ctl_q[0][BIT_GATE] &&
       ctl_q[0][5:4] == 2'b01 && !cpu_idle) |=> !tick[0] [*7])
      else $error("prescale 1:8 ticked early");
   a_gate_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (ctl_q[0][BIT_GATE] && !ctl_q[0][BIT_CSRC] && !gate_s2_q[0])
      |-> !tick[0])
      else $error("gated timer advanced with gate low");
   c_pair_wrap: cover property (@(posedge sys_clk)
      pair_on[0] && wrap[1]);
   c_gate_fall: cover property (@(posedge sys_clk) gate_evt[0]);
   c_ext_tick:  cover property (@(posedge sys_clk)
      tick[2] && ctl_q[2][BIT_CSRC]);

endmodule

// ==== testbench/tb_paired_16_32_bit_timer.sv ====
// Register-level testbench for the paired 16/32-bit timer block
`timescale 1ns/1ps
module tb_paired_16_32_bit_timer;
   import ptm_pkg::*;
   logic        sys_clk;
   logic        rst;
   logic [3:0]  ext_count_pin;
   logic [3:0]  gate_pin;
   logic        cpu_idle;
   logic [1:0]  pair_irq;
   logic [1:0]  low_irq;
   logic [5:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [5:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   int          err_total;
   int          comparisons;
   logic [31:0] rd;
   logic [1:0]  rs;

   ptm_timer u_dut (.sys_clk(sys_clk), .rst(rst),
      .ext_count_pin(ext_count_pin), .gate_pin(gate_pin),
      .cpu_idle(cpu_idle), .pair_irq(pair_irq), .low_irq(low_irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // -------------------------------------------------------------
   // Clock, reset and watchdog
   // -------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      err_total++;
      print_verdict();
   end

   // -------------------------------------------------------------
   // Bus tasks and compares
   // -------------------------------------------------------------
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge sys_clk);
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // Idle edge so bready never toggles twice in one step
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge sys_clk);
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      // Idle edge so rready never toggles twice in one step
      @(posedge sys_clk);
   endtask
   task automatic check_eq(input string what, input logic [31:0] e,
                           input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_rng(input string what, input int lo, input int hi,
                            input logic [31:0] g);
      comparisons++;
      if ($isunknown(g) || g < lo || g > hi) begin
         err_total++;
         $display("ERROR %s expected %0d..%0d seen %h", what, lo, hi, g);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      err_total = 0;
      comparisons = 0;
      rst = 1'b1;
      ext_count_pin = 4'h0;
      gate_pin = 4'h0;
      cpu_idle = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd_reg(OFF_CTL_LO_A, rd, rs);
      check_eq("ctl_lo_a", 32'h0, rd);
      rd_reg(OFF_PER_LO_A, rd, rs);
      check_eq("per_lo_a", 32'hffff, rd);
      rd_reg(OFF_IRQ, rd, rs);
      check_eq("irq", 32'h0, rd);
      rd_reg(6'h34, rd, rs);
      check_eq("unmapped resp", RESP_SLVERR, rs);
      check_eq("unmapped data", 32'h0, rd);
      axi_wr(6'h38, 32'h1, rs);
      check_eq("unmapped wr", RESP_SLVERR, rs);
      // Partial strobes leave a timer register alone
      wstrb <= 4'hc;
      wr(OFF_PER_LO_A, 32'h1234);
      wstrb <= 4'hf;
      rd_reg(OFF_PER_LO_A, rd, rs);
      check_eq("strobe ignored", 32'hffff, rd);
      $display("Test reset and decode done");
      wr(OFF_CTL_LO_A, 32'hffff_7ff5);
      rd_reg(OFF_CTL_LO_A, rd, rs);
      check_eq("ctl_lo mask", 32'h2070, rd);
      wr(OFF_CTL_HI_A, 32'hffff);
      rd_reg(OFF_CTL_HI_A, rd, rs);
      check_eq("ctl_hi rd", 32'ha072, rd);
      wr(OFF_CTL_LO_A, 32'h0);
      wr(OFF_CTL_HI_A, 32'h0);
      $display("Test control masks done");
      for (int c = 0; c < 4; c++) begin
         int sh;
         sh = (c == 0) ? 0 : (c == 1) ? 3 : (c == 2) ? 6 : 8;
         wr(OFF_CNT_LO_A, 32'h0);
         wr(OFF_CTL_LO_A, 32'h8000 | (c << 4));
         repeat (2048) @(posedge sys_clk);
         wr(OFF_CTL_LO_A, 32'h0);
         rd_reg(OFF_CNT_LO_A, rd, rs);
         check_rng("prescaled", (2048 >> sh) - 1, (2056 >> sh) + 1, rd);
      end
      $display("Test prescale done");
      wr(OFF_CNT_LO_A, 32'h0);
      wr(OFF_CTL_LO_A, 32'h8040);
      repeat (20) @(posedge sys_clk);
      gate_pin[0] <= 1'b1;
      repeat (100) @(posedge sys_clk);
      gate_pin[0] <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_A, rd, rs);
      check_rng("gated cnt", 97, 104, rd);
      rd_reg(OFF_IRQ, rd, rs);
      check_eq("gate flag", 32'h1, rd & 32'hf);
      wr(OFF_CTL_LO_A, 32'h0);
      wr(OFF_IRQ, 32'h0);
      $display("Test gated done");
      wr(OFF_CNT_LO_A, 32'h0);
      wr(OFF_PER_LO_A, 32'h3);
      wr(OFF_IRQ, 32'h10);
      wr(OFF_CTL_LO_A, 32'h8000);
      repeat (20) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_A, rd, rs);
      check_rng("wrap cnt", 0, 3, rd);
      rd_reg(OFF_IRQ, rd, rs);
      check_eq("match flag", 32'h11, rd & 32'hff);
      check_eq("low irq", 32'h1, {30'h0, low_irq});
      wr(OFF_CTL_LO_A, 32'h0);
      wr(OFF_IRQ, 32'h0);
      $display("Test period done");
      wr(OFF_PER_LO_A, 32'h0100);
      wr(OFF_PER_HI_A, 32'h1);
      wr(OFF_CNT_LO_A, 32'hfff0);
      wr(OFF_CNT_HI_A, 32'h0);
      wr(OFF_CTL_HI_A, 32'h0072);
      wr(OFF_IRQ, 32'h30);
      wr(OFF_CTL_LO_A, 32'h8008);
      repeat (40) @(posedge sys_clk);
      wr(OFF_CTL_LO_A, 32'h0008);
      rd_reg(OFF_CNT_HI_A, rd, rs);
      check_eq("carry hi", 32'h1, rd);
      rd_reg(OFF_CNT_LO_A, rd, rs);
      check_rng("pair lo", 16, 48, rd);
      rd_reg(OFF_IRQ, rd, rs);
      check_eq("no flag", 32'h0, rd & 32'hf);
      wr(OFF_CTL_LO_A, 32'h8008);
      repeat (300) @(posedge sys_clk);
      rd_reg(OFF_IRQ, rd, rs);
      check_eq("pair flag", 32'h2, rd & 32'hf);
      check_eq("pair irq", 32'h1, {30'h0, pair_irq});
      check_eq("low masked", 32'h0, {30'h0, low_irq});
      wr(OFF_CTL_LO_A, 32'h0);
      wr(OFF_IRQ, 32'h0);
      $display("Test pair done");
      // idle halt on timer four and on pair A
      cpu_idle <= 1'b1;
      wr(OFF_CTL_LO_B, 32'ha000);
      repeat (50) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_B, rd, rs);
      check_eq("idle halt", 32'h0, rd);
      wr(OFF_CTL_LO_B, 32'h8000);
      repeat (50) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_B, rd, rs);
      check_rng("idle run", 50, 60, rd);
      wr(OFF_CNT_LO_A, 32'h0);
      wr(OFF_CTL_HI_A, 32'h2000);
      wr(OFF_CTL_LO_A, 32'h8008);
      repeat (20) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_A, rd, rs);
      check_eq("pair idle halt", 32'h0, rd);
      wr(OFF_CTL_HI_A, 32'h0);
      repeat (20) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_A, rd, rs);
      check_rng("pair idle run", 20, 30, rd);
      wr(OFF_CTL_LO_A, 32'h0);
      cpu_idle <= 1'b0;
      $display("Test idle done");
      wr(OFF_CTL_LO_B, 32'h0002);
      wr(OFF_CNT_LO_B, 32'h0);
      wr(OFF_CTL_LO_B, 32'h8002);
      for (int i = 0; i < 8; i++) begin
         if (i == 5)
            wr(OFF_CTL_LO_B, 32'h8042);
         ext_count_pin[2] <= 1'b1;
         repeat (4) @(posedge sys_clk);
         ext_count_pin[2] <= 1'b0;
         repeat (4) @(posedge sys_clk);
         if (i == 4) begin
            rd_reg(OFF_CNT_LO_B, rd, rs);
            check_eq("ext cnt", 32'h5, rd);
         end
      end
      repeat (8) @(posedge sys_clk);
      rd_reg(OFF_CNT_LO_B, rd, rs);
      check_eq("gate ignored", 32'h8, rd);
      $display("Test external count done");
      print_verdict();
   end
endmodule
